// ===== rtl/acr_params.svh
// Register map, field layout, reset values and timing constants
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_OFF_CLK 12'h000
`define ACR_OFF_MOD0 12'h004
`define ACR_OFF_MOD1 12'h008
`define ACR_OFF_STAT 12'h00c

`define ACR_CLK_RESET 8'h80
`define ACR_HOLD_MSB 7
`define ACR_HOLD_LSB 4
`define ACR_PRE_MSB 2
`define ACR_PRE_LSB 0
`define ACR_MOD0_START 0
`define ACR_MOD1_REFON 7

`define ACR_HOLD_8 4'h8
`define ACR_HOLD_24 4'ha
`define ACR_HOLD_32 4'hb
`define ACR_HOLD_64 4'h3
`define ACR_HOLD_128 4'hc
`define ACR_HOLD_512 4'hd

`define ACR_CYC_8 10'h008
`define ACR_CYC_24 10'h018
`define ACR_CYC_32 10'h020
`define ACR_CYC_64 10'h040
`define ACR_CYC_128 10'h080
`define ACR_CYC_512 10'h200

`define ACR_CONV_TAIL 10'h026
`define ACR_CONV_MIN 10'h02e
`define ACR_PRE_MAX 3'h4
`define ACR_DIV_SLOW 5'h10

`endif

// ===== rtl/acr_pkg.sv
// Types shared by the conversion clock block
package acr_pkg;
    typedef enum logic [1:0] {
        acr_idle,
        acr_sample,
        acr_convert
    } acr_state_type;
endpackage

// ===== rtl/acr_prescaler.sv
// Main clock divider producing the conversion clock tick
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_prescaler
    import acr_pkg::*;
#(
    parameter int DIV_BITS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] select,
    output logic tick
);
    logic [DIV_BITS-1:0] count;
    logic [DIV_BITS-1:0] limit;
    logic wrap;

    // Reserved codes fall back to the slowest divider, the safe side
    assign limit = (select > `ACR_PRE_MAX) ? {DIV_BITS{1'b1}} :
        DIV_BITS'((5'h01 << select) - 5'h01);
    assign wrap = (count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
            tick <= wrap;
        end
    end

    // Select 000 ticks every cycle once out of reset
    a_tick_undivided: assert property (
        @(posedge pclk) disable iff (!presetn)
        (presetn && select == 3'h0) [*2] |-> tick)
        else $error("undivided clock missed a tick");
endmodule // acr_prescaler

// ===== rtl/acr_top.sv
// Conversion clock, sample-hold timing and reference control over APB
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_top
    import acr_pkg::*;
#(
    parameter int CNT_BITS = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic reference_enable,
    output logic sample_hold,
    output logic converter_busy,
    output logic conversion_clock_tick,
    output logic conversion_done
);
    logic [7:0] conversion_clock_setting;
    logic [7:0] next_clock_setting;
    logic [CNT_BITS-1:0] count;
    logic [CNT_BITS-1:0] hold_clocks;
    logic [CNT_BITS-1:0] next_count;
    acr_state_type state;
    acr_state_type next_state;
    logic tick;
    logic access;
    logic wr;
    logic rd;
    logic hit_clk;
    logic hit_mod0;
    logic hit_mod1;
    logic hit_stat;
    logic mapped;
    logic start_req;
    logic next_done;
    logic [31:0] read_mux;

    function automatic logic [CNT_BITS-1:0] hold_decode(input logic [3:0] c);
        case (c)
            `ACR_HOLD_8: hold_decode = CNT_BITS'(`ACR_CYC_8);
            `ACR_HOLD_24: hold_decode = CNT_BITS'(`ACR_CYC_24);
            `ACR_HOLD_32: hold_decode = CNT_BITS'(`ACR_CYC_32);
            `ACR_HOLD_64: hold_decode = CNT_BITS'(`ACR_CYC_64);
            `ACR_HOLD_128: hold_decode = CNT_BITS'(`ACR_CYC_128);
            `ACR_HOLD_512: hold_decode = CNT_BITS'(`ACR_CYC_512);
            // Reserved codes take the shortest hold, keeping 46 minimum
            default: hold_decode = CNT_BITS'(`ACR_CYC_8);
        endcase
    endfunction

    // Divide ratio per prescaler code; reserved codes run slowest
    function automatic logic [4:0] divide_of(input logic [2:0] s);
        divide_of = (s > `ACR_PRE_MAX) ? `ACR_DIV_SLOW : 5'h01 << s;
    endfunction

    acr_prescaler #(
        .DIV_BITS(4)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .select(conversion_clock_setting[`ACR_PRE_MSB:`ACR_PRE_LSB]),
        .tick(tick)
    );

    // Zero wait state slave: every access completes in its access phase
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign hit_clk = (paddr == `ACR_OFF_CLK);
    assign hit_mod0 = (paddr == `ACR_OFF_MOD0);
    assign hit_mod1 = (paddr == `ACR_OFF_MOD1);
    assign hit_stat = (paddr == `ACR_OFF_STAT);
    assign mapped = hit_clk || hit_mod0 || hit_mod1 || hit_stat;

    assign next_clock_setting = (wr && hit_clk) ?
        {pwdata[`ACR_HOLD_MSB:`ACR_HOLD_LSB], 1'b0,
        pwdata[`ACR_PRE_MSB:`ACR_PRE_LSB]} : conversion_clock_setting;

    assign start_req = wr && hit_mod0 && pwdata[`ACR_MOD0_START];

    assign hold_clocks = hold_decode(
        conversion_clock_setting[`ACR_HOLD_MSB:`ACR_HOLD_LSB]);

    always_comb begin
        next_state = state;
        next_count = count;
        next_done = 1'b0;
        case (state)
            acr_idle: begin
                if (start_req) begin
                    next_state = acr_sample;
                    next_count = hold_clocks;
                end
            end
            acr_sample: begin
                if (tick) begin
                    if (count == CNT_BITS'(1)) begin
                        next_state = acr_convert;
                        next_count = CNT_BITS'(`ACR_CONV_TAIL);
                    end else begin
                        next_count = count - 1'b1;
                    end
                end
            end
            acr_convert: begin
                if (tick) begin
                    if (count == CNT_BITS'(1)) begin
                        next_state = acr_idle;
                        next_count = '0;
                        next_done = 1'b1;
                    end else begin
                        next_count = count - 1'b1;
                    end
                end
            end
            default: begin
                next_state = acr_idle;
                next_count = '0;
            end
        endcase
    end

    assign read_mux = hit_clk ? {24'h000000, conversion_clock_setting} :
        hit_mod1 ? {24'h000000, reference_enable, 7'h00} :
        hit_stat ? {30'h0, converter_busy, sample_hold} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_clock_setting <= `ACR_CLK_RESET;
            reference_enable <= 1'b0;
            state <= acr_idle;
            count <= '0;
        end else begin
            conversion_clock_setting <= next_clock_setting;
            if (wr && hit_mod1) begin
                reference_enable <= pwdata[`ACR_MOD1_REFON];
            end
            state <= next_state;
            count <= next_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            sample_hold <= 1'b0;
            converter_busy <= 1'b0;
            conversion_clock_tick <= 1'b0;
            conversion_done <= 1'b0;
        end else begin
            // Ready one cycle into setup so the access phase ends at once
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable) ? read_mux : prdata;
            sample_hold <= (next_state == acr_sample);
            converter_busy <= (next_state != acr_idle);
            conversion_clock_tick <= tick;
            conversion_done <= next_done;
        end
    end

    // minimum conversion length, counted in conversion clocks
    logic [CNT_BITS:0] conv_ticks;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_ticks <= '0;
        end else if (state == acr_idle) begin
            conv_ticks <= '0;
        end else if (tick) begin
            conv_ticks <= conv_ticks + 1'b1;
        end
    end

    // tick spacing, judged only once the field has settled
    logic [4:0] tick_gap;
    logic [4:0] pre_age;
    logic tick_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_gap <= '0;
            pre_age <= '0;
            tick_seen <= 1'b0;
        end else begin
            tick_gap <= tick ? 5'h01 : tick_gap + 1'b1;
            tick_seen <= tick_seen || tick;
            if (wr && hit_clk) begin
                pre_age <= '0;
            end else if (!(&pre_age)) begin
                pre_age <= pre_age + 1'b1;
            end
        end
    end

    a_conv_min_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        next_done |-> (conv_ticks + 1'b1) >= (CNT_BITS+1)'(`ACR_CONV_MIN))
        else $error("conversion ended before 46 clocks");

    a_conv_exact_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        next_done |-> (conv_ticks + 1'b1) ==
            (CNT_BITS+1)'(hold_clocks) + (CNT_BITS+1)'(`ACR_CONV_TAIL))
        else $error("conversion length not hold plus tail");

    a_hold_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state == acr_idle && start_req) |=> (count == $past(hold_clocks)))
        else $error("hold count not loaded from field");

    a_bit3_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_clock_setting[3] == 1'b0)
        else $error("clock setting bit 3 not zero");

    a_ref_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_mod1) |=>
            reference_enable == $past(pwdata[`ACR_MOD1_REFON]))
        else $error("reference enable did not follow write");

    a_start_launch: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state == acr_idle && start_req) |=> converter_busy && sample_hold)
        else $error("start write did not launch conversion");

    a_pre_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_clk) |=>
            conversion_clock_setting[2:0] == $past(pwdata[2:0]))
        else $error("prescaler field not written");

    a_hold_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_clk) |=>
            conversion_clock_setting[`ACR_HOLD_MSB:`ACR_HOLD_LSB] ==
            $past(pwdata[`ACR_HOLD_MSB:`ACR_HOLD_LSB]))
        else $error("hold field not written");

    a_hold_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state == acr_sample && next_state == acr_convert) |->
            (conv_ticks + 1'b1) == (CNT_BITS+1)'(hold_clocks))
        else $error("sample hold phase not the selected length");

    a_tail_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state == acr_sample && next_state == acr_convert) |=>
            count == CNT_BITS'(`ACR_CONV_TAIL))
        else $error("tail count not loaded after sample hold");

    a_done_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_done |-> !converter_busy ##1 !conversion_done)
        else $error("done not a single cycle at end of busy");

    a_tick_rate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tick && tick_seen && (&pre_age)) |-> tick_gap ==
            divide_of(conversion_clock_setting[`ACR_PRE_MSB:`ACR_PRE_LSB]))
        else $error("conversion clock period differs from divider");

    a_bit3_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_clk) |=> prdata[3] == 1'b0)
        else $error("clock setting bit 3 read back as one");

    a_unmapped_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    a_read_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd |=> $stable(conversion_clock_setting) &&
            $stable(reference_enable))
        else $error("read access changed a register");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("access phase not answered"); 
endmodule // acr_top

// ===== tb/tb.sv
// Self-checking bench for the conversion clock and reference block
`timescale 1ns/100ps
`include "acr_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, d;
    logic pready, pslverr, err;
    logic reference_enable, sample_hold, converter_busy;
    logic conversion_clock_tick, conversion_done;
    int n_mismatch = 0;
    int checks = 0;
    int busy_n = 0;
    int sh_n = 0;
    int since = 0;
    int gap = 0;
    logic [7:0] exp_clk = 8'h80;
    logic [3:0] holds [6] = '{`ACR_HOLD_8, `ACR_HOLD_24, `ACR_HOLD_32,
        `ACR_HOLD_64, `ACR_HOLD_128, `ACR_HOLD_512};

    always #25 pclk = ~pclk;

    acr_top acr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_enable(reference_enable), .sample_hold(sample_hold),
        .converter_busy(converter_busy),
        .conversion_clock_tick(conversion_clock_tick),
        .conversion_done(conversion_done));

    // Counters see pre-edge values, so no race with the design's updates
    always @(posedge pclk) begin
        if (converter_busy === 1'b1) busy_n <= busy_n + 1;
        if (sample_hold === 1'b1) sh_n <= sh_n + 1;
        if (conversion_clock_tick === 1'b1) begin
            gap <= since;
            since <= 1;
        end else begin
            since <= since + 1;
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // A hung slave is caught by the watchdog only
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic int hold_clk(input logic [3:0] c);
        case (c)
            `ACR_HOLD_24: return 24;
            `ACR_HOLD_32: return 32;
            `ACR_HOLD_64: return 64;
            `ACR_HOLD_128: return 128;
            `ACR_HOLD_512: return 512;
            default: return 8;
        endcase
    endfunction

    function automatic int dv(input logic [2:0] p);
        return (p <= 3'h4) ? (1 << p) : 16;
    endfunction

    function automatic logic near(input int got, input int exp, input int t);
        return (got >= exp - t) && (got <= exp + t);
    endfunction

    task automatic conv(input logic [3:0] h, input logic [2:0] p);
        int t;
        t = dv(p) + 2;
        apb(1'b1, `ACR_OFF_CLK, {24'h0, h, 1'b0, p});
        exp_clk = {h, 1'b0, p};
        busy_n = 0;
        sh_n = 0;
        apb(1'b1, `ACR_OFF_MOD0, 32'h1);
        apb(1'b0, `ACR_OFF_STAT, 32'h0);
        `CHK(rd[1], 1'b1)
        // Second start mid-conversion must not stretch it
        apb(1'b1, `ACR_OFF_MOD0, 32'h1);
        while (conversion_done !== 1'b1) begin
            @(posedge pclk);
        end
        @(posedge pclk);
        #1;
        `CHK(near(busy_n, (hold_clk(h) + 38) * dv(p), t), 1'b1)
        `CHK(near(busy_n, 46 * dv(p), t) || busy_n > 46 * dv(p), 1'b1)
        `CHK(near(sh_n, hold_clk(h) * dv(p), t), 1'b1)
        `CHK(gap, dv(p))
        apb(1'b0, `ACR_OFF_CLK, 32'h0);
        `CHK(rd, {24'h0, exp_clk})
    endtask

    task automatic close_out();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        // Tests need about 32k cycles; this allows 50k
        #2_500_000;
        n_mismatch++;
        close_out();
    end

    initial begin
        void'($urandom(32'h81f2));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ACR_OFF_CLK, 32'h0);
        `CHK(rd, {24'h0, `ACR_CLK_RESET})
        repeat (4) begin
            d = $urandom;
            // listed codes only; bit 3 set to probe
            d[7:4] = holds[$urandom % 6];
            d[3] = 1'b1;
            d[2:0] = 3'($urandom % 5);
            apb(1'b1, `ACR_OFF_CLK, d);
            exp_clk = d[7:0] & 8'hf7;
            apb(1'b0, `ACR_OFF_CLK, 32'h0);
            `CHK(rd, {24'h0, exp_clk})
        end
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // reference path follows the enable bit
        apb(1'b1, `ACR_OFF_MOD1, 32'h80);
        #1;
        `CHK(reference_enable, 1'b1)
        apb(1'b1, `ACR_OFF_MOD1, 32'h0);
        #1;
        `CHK(reference_enable, 1'b0)
        // enable reference, settle 3 us, then start
        apb(1'b1, `ACR_OFF_MOD1, 32'h80);
        repeat (60) @(posedge pclk);
        // listed codes; 20 MHz stays under limit
        for (int p = 0; p < 5; p++)
            foreach (holds[i]) conv(holds[i], p[2:0]);
        close_out();
    end
endmodule // tb
